// *** hw/dibc_consts.svh ***
// Constants for the input bus and clock mode block
`ifndef DIBC_CONSTS_SVH
`define DIBC_CONSTS_SVH
`define DIBC_DATA_W       16
`define DIBC_SEL_2X       2'h0
`define DIBC_SEL_4X       2'h1
`define DIBC_SEL_8X       2'h2
`define DIBC_SEL_16X      2'h3
`define DIBC_STAGES       4
`define DIBC_DIV_W        4
`define DIBC_DUAL_BUS     1'h0
`define DIBC_INTERLEAVE   1'h1
`endif

// *** hw/dibc_pkg.sv ***
// Types shared by the input bus and clock mode block
package dibc_pkg;
  typedef enum logic [1:0] {DIBC_X2, DIBC_X4, DIBC_X8, DIBC_X16} dibc_rate_t;
  typedef enum logic {DIBC_PHASE_A, DIBC_PHASE_B} dibc_phase_t;
endpackage

// *** hw/dibc_stage_if.sv ***
// Carrier between the top and the stage clock divider
`timescale 1ns/10ps
`default_nettype none
interface dibc_stage_if;
  logic [1:0] rateSel;
  logic [3:0] stageEn;
  logic [3:0] stageActive;
  logic       dataClk;
  modport ctl (output rateSel, input stageEn, input stageActive, input dataClk);
  modport div (input rateSel, output stageEn, output stageActive, output dataClk);
endinterface
`default_nettype wire

// *** hw/dibc_stage_div.sv ***
// Sub-harmonic enable divider for the interpolation filter chain
`timescale 1ns/10ps
`default_nettype none
`include "dibc_consts.svh"
module dibc_stage_div
  import dibc_pkg::*;
#(
  parameter int STAGES = `DIBC_STAGES
)
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Divider carrier
  dibc_stage_if.div stg
);
  initial if (STAGES != `DIBC_STAGES) $error("dibc_stage_div: STAGES must be 4");

  logic [`DIBC_DIV_W-1:0] cnt_reg;
  logic [`DIBC_DIV_W-1:0] cnt_next;
  logic [STAGES-1:0]      en_next;
  logic [STAGES-1:0]      en_reg;

  // Stage n ticks once per 2^(n+1) sample clocks
  genvar g;
  generate
    for (g = 0; g < STAGES; g++)
    begin : g_stage
      assign en_next[g] = &cnt_next[g:0];
      assign stg.stageActive[g] = (g <= int'(stg.rateSel));
    end
  endgenerate

  always_comb
  begin
    cnt_next = cnt_reg + `DIBC_DIV_W'(1);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      en_reg  <= '0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      en_reg  <= en_next;
    end
  end

  assign stg.stageEn = en_reg & stg.stageActive;
  // Data clock runs at sample rate divided by the interpolation factor
  assign stg.dataClk = cnt_reg[stg.rateSel];

  a_stage_one_rate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stg.stageEn[0] |=> !stg.stageEn[0] ##1 stg.stageEn[0])
    else $error("First stage enable not at half rate");
  a_stage_cascade: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stg.stageEn[1] |-> stg.stageEn[0] && stg.rateSel != `DIBC_SEL_2X)
    else $error("Second stage active at lowest factor");
  c_stage_all: cover property (@(posedge sys_clk) disable iff (!rst_n) stg.stageEn[3]);
endmodule // dibc_stage_div
`default_nettype wire

// *** hw/dibc_input_ctl.sv ***
// Input bus arrangement, clock mode and filter stage clocking
// Overview of operation
// - PLL enabled drives lock indicator on pin
// - Stage n clocked at sample rate/2^(n+1)
// - 2x one stage; each doubling adds one
// - Interleave select low gives dual-bus mode
// - Dual-bus: capture A as I, B as Q
// - PLL mode uses PLL sample tick, else external
// - External mode outputs sample clock/factor; dual-clock drives pin low
// - Interleave: alternate A words to A, B
`timescale 1ns/10ps
`default_nettype none
`include "dibc_consts.svh"
module dibc_input_ctl
  import dibc_pkg::*;
#(
  parameter int DATA_W = `DIBC_DATA_W
)
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Configuration
  input  wire logic              busInterleaveSelect,
  input  wire logic              pllEnable,
  input  wire logic              dualClockMode,
  input  wire logic [1:0]        rateSel,
  input  wire logic [1:0]        rangeDiv,
  input  wire logic              txEnable,
  // Clock sources
  input  wire logic              pllLocked,
  input  wire logic              pllSampleTick,
  input  wire logic              extSampleTick,
  // Data buses
  input  wire logic [DATA_W-1:0] dataBusA,
  input  wire logic [DATA_W-1:0] dataBusB,
  // Channel outputs
  output logic [DATA_W-1:0]      chanAData,
  output logic [DATA_W-1:0]      chanBData,
  output logic                   chanValid,
  // Status and clocking outputs
  output logic                   lockOrClockOutput,
  output logic                   sampleTick,
  output logic [3:0]             stageEn,
  output logic [1:0]             pllRangeSel
);
  initial if (DATA_W < 1) $error("dibc_input_ctl: DATA_W must be positive");

  dibc_stage_if stg ();

  dibc_stage_div #(.STAGES(`DIBC_STAGES)) u_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .stg     (stg)
  );

  assign stg.rateSel = rateSel;
  assign stageEn     = stg.stageEn;
  assign pllRangeSel = rangeDiv;

  // ==========================================================
  // Clock mode
  logic pinOut_reg;
  logic pinOut_next;

  always_comb
  begin
    sampleTick = pllEnable ? pllSampleTick : extSampleTick;
    if (pllEnable)
      pinOut_next = pllLocked;
    else if (dualClockMode)
      pinOut_next = 1'h0;
    else
      pinOut_next = stg.dataClk;
  end

  // ==========================================================
  // Data capture
  dibc_phase_t       phase_reg;
  dibc_phase_t       phase_next;
  logic              txPrev_reg;
  logic [DATA_W-1:0] a_reg;
  logic [DATA_W-1:0] a_next;
  logic [DATA_W-1:0] b_reg;
  logic [DATA_W-1:0] b_next;
  logic              valid_reg;
  logic              valid_next;

  always_comb
  begin
    a_next     = a_reg;
    b_next     = b_reg;
    phase_next = phase_reg;
    valid_next = 1'h0;
    if (busInterleaveSelect == `DIBC_DUAL_BUS)
    begin
      a_next     = dataBusA;
      b_next     = dataBusB;
      valid_next = 1'h1;
      phase_next = DIBC_PHASE_A;
    end
    else
    begin
      case (phase_reg)
        DIBC_PHASE_A:
        begin
          a_next     = dataBusA;
          phase_next = DIBC_PHASE_B;
        end
        DIBC_PHASE_B:
        begin
          b_next     = dataBusA;
          valid_next = 1'h1;
          phase_next = DIBC_PHASE_A;
        end
        default: phase_next = DIBC_PHASE_A;
      endcase
      if (txEnable && !txPrev_reg)
      begin
        a_next     = dataBusA;
        phase_next = DIBC_PHASE_B;
        valid_next = 1'h0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg  <= DIBC_PHASE_A;
      txPrev_reg <= 1'h0;
      a_reg      <= '0;
      b_reg      <= '0;
      valid_reg  <= 1'h0;
      pinOut_reg <= 1'h0;
    end
    else
    begin
      phase_reg  <= phase_next;
      txPrev_reg <= txEnable;
      a_reg      <= a_next;
      b_reg      <= b_next;
      valid_reg  <= valid_next;
      pinOut_reg <= pinOut_next;
    end
  end

  assign chanAData         = a_reg;
  assign chanBData         = b_reg;
  assign chanValid         = valid_reg;
  assign lockOrClockOutput = pinOut_reg;

  // ==========================================================
  // Checks
  a_lock_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pllEnable |=> lockOrClockOutput == $past(pllLocked))
    else $error("Lock pin does not follow PLL lock");
  a_dual_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !busInterleaveSelect |=> chanAData == $past(dataBusA) && chanBData == $past(dataBusB))
    else $error("Dual-bus capture mismatch");
  a_dual_valid: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !busInterleaveSelect |=> chanValid)
    else $error("Dual-bus mode not streaming");
  a_clk_source: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sampleTick == (pllEnable ? pllSampleTick : extSampleTick))
    else $error("Wrong sample clock source");
  a_ext_clock_out: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !pllEnable && !dualClockMode |=> lockOrClockOutput == $past(stg.dataClk))
    else $error("Divided clock not on pin");
  a_ilv_alternate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busInterleaveSelect && !(txEnable && !txPrev_reg) && phase_reg == DIBC_PHASE_B
    |=> chanBData == $past(dataBusA) && chanValid)
    else $error("Interleave B word not captured");
  a_ilv_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busInterleaveSelect && txEnable && !txPrev_reg |=> chanAData == $past(dataBusA))
    else $error("Interleave restart not on channel A");
  a_range_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pllRangeSel == rangeDiv && stg.rateSel == rateSel)
    else $error("Range or rate select lost");
  c_dual: cover property (@(posedge sys_clk) disable iff (!rst_n) !busInterleaveSelect ##1 chanValid);
  c_ilv: cover property (@(posedge sys_clk) disable iff (!rst_n) busInterleaveSelect ##2 chanValid);
  c_pll: cover property (@(posedge sys_clk) disable iff (!rst_n) pllEnable && pllLocked);
endmodule // dibc_input_ctl
`default_nettype wire

// *** bench/dibc_src_model.sv ***
// Far-side source model driving the input data buses
`timescale 1ns/10ps
`default_nettype none
module dibc_src_model
(
  // Clock
  input  wire logic   sys_clk,
  // Source outputs
  output logic [15:0] dataBusA,
  output logic [15:0] dataBusB,
  output logic        txEnable
);
  // ==========
  // Word driver, changes just after the falling edge
  initial
  begin
    dataBusA = 16'h0000;
    dataBusB = 16'hffff;
    txEnable = 1'h0;
  end
  task automatic put(input logic [15:0] a, input logic [15:0] b, input logic tx);
    @(negedge sys_clk);
    dataBusA <= a;
    dataBusB <= b;
    txEnable <= tx;
  endtask
endmodule // dibc_src_model
`default_nettype wire

// *** bench/test_dac_input_bus_clock_mode.sv ***
// Self-checking bench for the input bus and clock mode block
`timescale 1ns/10ps
`default_nettype none
module test_dac_input_bus_clock_mode;
  import dibc_pkg::*;
  logic        sys_clk, rst_n, busInterleaveSelect, pllEnable, dualClockMode, txEnable;
  logic        pllLocked, pllSampleTick, extSampleTick, chanValid, lockOrClockOutput;
  logic        sampleTick, prevLock;
  logic [1:0]  rateSel, rangeDiv, pllRangeSel;
  logic [15:0] dataBusA, dataBusB, chanAData, chanBData;
  logic [3:0]  stageEn;
  int          err_count, checks, cyc, rises;
  int          ones [4];
  // ==========
  // Clock, source and design
  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  dibc_src_model u_src (.sys_clk(sys_clk), .dataBusA(dataBusA), .dataBusB(dataBusB),
    .txEnable(txEnable));
  dibc_input_ctl u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .busInterleaveSelect(busInterleaveSelect), .pllEnable(pllEnable),
    .dualClockMode(dualClockMode), .rateSel(rateSel), .rangeDiv(rangeDiv),
    .txEnable(txEnable), .pllLocked(pllLocked), .pllSampleTick(pllSampleTick),
    .extSampleTick(extSampleTick), .dataBusA(dataBusA), .dataBusB(dataBusB),
    .chanAData(chanAData), .chanBData(chanBData), .chanValid(chanValid),
    .lockOrClockOutput(lockOrClockOutput), .sampleTick(sampleTick),
    .stageEn(stageEn), .pllRangeSel(pllRangeSel));
  // ==========
  // Helpers
  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      err_count++;
      test_done();
    end
  end
  // ==========
  // Tests
  initial
  begin
    {rst_n, busInterleaveSelect, dualClockMode, pllLocked, extSampleTick} = 5'h00;
    {pllEnable, pllSampleTick, rateSel, rangeDiv} = 6'h30;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk) rst_n = 1'h1;
    u_src.put(16'h1234, 16'hbeef, 1'h0);
    tick(2);
    chk("chanA", 16'h1234, chanAData);
    chk("chanB", 16'hbeef, chanBData);
    chk("valid", 16'h1, 16'(chanValid));
    $display("test dual_bus done");
    for (int r = 0; r < 4; r++)
    begin
      rateSel = 2'(r);
      rangeDiv = 2'(3 - r);
      pllLocked = r[0];
      tick(2);
      chk("lock", 16'(r[0]), 16'(lockOrClockOutput));
      chk("range", 16'(3 - r), 16'(pllRangeSel));
    end
    chk("tickPll", 16'h1, 16'(sampleTick));
    @(negedge sys_clk) pllEnable = 1'h0;
    tick(1);
    chk("tickExt", 16'h0, 16'(sampleTick));
    $display("test pll_lock done");
    for (int r = 0; r < 4; r++)
    begin
      rateSel = 2'(r);
      tick(3);
      rises = 0;
      ones = '{0, 0, 0, 0};
      prevLock = lockOrClockOutput;
      repeat (64)
      begin
        tick(1);
        rises += int'(lockOrClockOutput & ~prevLock);
        prevLock = lockOrClockOutput;
        for (int b = 0; b < 4; b++)
          ones[b] += int'(stageEn[b]);
      end
      chk("divClk", 16'(64 >> (r + 1)), 16'(rises));
      for (int b = 0; b < 4; b++)
        chk("stageEn", (b <= r) ? 16'(64 >> (b + 1)) : 16'h0, 16'(ones[b]));
    end
    dualClockMode = 1'h1;
    tick(3);
    chk("lockDual", 16'h0, 16'(lockOrClockOutput));
    $display("test ext_clock done");
    busInterleaveSelect = 1'h1;
    tick(2);
    u_src.put(16'h0a11, 16'h5555, 1'h1);
    u_src.put(16'h0b22, 16'haaaa, 1'h1);
    u_src.put(16'h0c33, 16'h5555, 1'h1);
    chk("ilvA", 16'h0a11, chanAData);
    chk("ilvB", 16'h0b22, chanBData);
    chk("ilvValid", 16'h1, 16'(chanValid));
    u_src.put(16'h0d44, 16'haaaa, 1'h1);
    chk("ilvHalf", 16'h0, 16'(chanValid));
    chk("ilvA2", 16'h0c33, chanAData);
    u_src.put(16'h0e55, 16'h5555, 1'h0);
    chk("ilvB2", 16'h0d44, chanBData);
    u_src.put(16'h0f66, 16'haaaa, 1'h1);
    u_src.put(16'h0077, 16'h5555, 1'h1);
    u_src.put(16'h0088, 16'haaaa, 1'h1);
    chk("ilvRestartA", 16'h0f66, chanAData);
    chk("ilvRestartB", 16'h0077, chanBData);
    $display("test interleave done");
    test_done();
  end
endmodule // test_dac_input_bus_clock_mode
`default_nettype wire
